// ==== include/cfp_defs.vh ====
`ifndef CFP_DEFS_VH
`define CFP_DEFS_VH

// Word indices on the Avalon-MM address
`define CFP_REG_CTRL     4'h0
`define CFP_REG_FSTAT    4'h1
`define CFP_REG_FADDR    4'h2
`define CFP_REG_FATTR    4'h3
`define CFP_REG_FDATA    4'h4
`define CFP_REG_RPCTRL   4'h5
`define CFP_REG_RPFLASH  4'h6
`define CFP_REG_RPRAM    4'h7
`define CFP_REG_RPBOOT   4'h8
`define CFP_REG_RPSP     4'h9
`define CFP_REG_RPILL    4'hA
`define CFP_REG_RPMIS    4'hB

// Control register fields
`define CFP_CTRL_ARB_RR     0
`define CFP_CTRL_STALL_DIS  1
`define CFP_CTRL_REVC_DIS   2
`define CFP_CTRL_SHADOW_DIS 3
`define CFP_CTRL_IBUF_DIS   4
`define CFP_CTRL_IRQ_EN     5
`define CFP_CTRL_W          6
`define CFP_CTRL_RESET      6'h00

// Fault status fields
`define CFP_FSTAT_ERR  0
`define CFP_FSTAT_LOST 1

// Fault attribute fields
`define CFP_FATTR_TYPE  0
`define CFP_FATTR_BUF   2
`define CFP_FATTR_SIZE  4
`define CFP_FATTR_DIR   6
`define CFP_FATTR_LOC   8

// Access size and location codes
`define CFP_SIZE_8      2'h0
`define CFP_SIZE_16     2'h1
`define CFP_SIZE_32     2'h2
`define CFP_LOC_INSTR   2'h0
`define CFP_LOC_OPA     2'h1
`define CFP_LOC_OPB     2'h2

// Protection control fields
`define CFP_RP_EN    0
`define CFP_RP_LOCK  1

// Captured program counter registers
`define CFP_PC_W      21
`define CFP_PC_VALID  31

// Avalon response codes
`define CFP_RESP_OK     2'h0
`define CFP_RESP_SLVERR 2'h2

`endif

// ==== src/cfp_arbiter.v ====
`timescale 1ns/1ps
`include "cfp_defs.vh"

module cfp_arbiter
(
	input wire mclk,
	input wire rst_n,
	input wire round_robin,
	input wire core_req,
	input wire dma_req,
	output reg grant_core,
	output reg grant_dma
);

reg last_core;
reg next_grant_core;
reg next_grant_dma;

always @*
begin
	next_grant_core = 1'b0;
	next_grant_dma = 1'b0;
	if (core_req && dma_req)
	begin
		if (!round_robin)
			next_grant_core = 1'b1;
		else
		begin
			next_grant_core = !last_core;
			next_grant_dma = last_core;
		end
	end
	else
	begin
		next_grant_core = core_req;
		next_grant_dma = dma_req;
	end
end

always @(posedge mclk)
begin
	if (!rst_n)
	begin
		grant_core <= 1'b0;
		grant_dma <= 1'b0;
		last_core <= 1'b0;
	end
	else
	begin
		grant_core <= next_grant_core;
		grant_dma <= next_grant_dma;
		if (next_grant_core || next_grant_dma)
			last_core <= next_grant_core;
	end
end

endmodule // cfp_arbiter

// ==== src/cfp_top.v ====
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "cfp_defs.vh"

// What this block does
// - Stall logic off: flash access during a flash command ends in bus error.
// - Stall logic on: flash access waits for the command, then runs without error.
// - Each faulted core access stores its address in a readable register.
// - Last faulted access keeps its size, direction and instruction/data type.
// - Last fault keeps which bus it came from: instruction, operand A or B.
// - Last faulted processor data write keeps its write data readable.
// - Interrupt enable set: every faulted bus cycle raises the error interrupt.
// - Any core bus error sets the fault error flag.
// - A bus error while the error flag is set also sets data-lost.
// - Software clears error and data-lost flags selectively, only those chosen.
// - Fixed priority: core always beats DMA on the same target.
// - Round robin: core and DMA equal, grants alternate on contention.
// - A control bit switches memory resource protection on or off.
// - Region settings act only when enabled, change only when disabled.
// - Once locked, protection registers ignore writes until system reset.
// - Illegal-access fault captures 21-bit program counter and sets its valid flag.
// - Illegal-fault valid flag clears on software request.
// - Misaligned fault captures 21-bit program counter and sets its valid flag.
// - Misaligned-fault valid flag clears on software request.
// - Reverse-carry disable set tells core to drop bit-reverse addressing.
// - Shadow-extension disable set keeps only baseline shadow registers.
// - Instruction buffer disable set turns off core longword instruction buffer.
// - Last faulted access also keeps bufferable or non-bufferable.
module cfp_top
#(
	parameter ADDR_W = 32,
	parameter DATA_W = 32,
	parameter BASE_W = 8
)
(
	input wire mclk,
	input wire rst_n,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg [1:0] avs_response,
	output reg avs_waitrequest,
	input wire fault_valid,
	input wire [ADDR_W-1:0] fault_addr,
	input wire [DATA_W-1:0] fault_wdata,
	input wire [1:0] fault_size,
	input wire fault_write,
	input wire fault_data,
	input wire fault_bufferable,
	input wire [1:0] fault_bus,
	output reg fault_irq,
	input wire flash_req,
	input wire flash_cmd_busy,
	output reg flash_go,
	output reg flash_berr,
	output reg flash_stall,
	input wire xbar_core_req,
	input wire xbar_dma_req,
	output wire xbar_grant_core,
	output wire xbar_grant_dma,
	input wire rp_illegal_fault,
	input wire rp_misaligned_fault,
	input wire [`CFP_PC_W-1:0] program_counter,
	output reg rp_enable_out,
	output reg [BASE_W-1:0] rp_flash_base_out,
	output reg [BASE_W-1:0] rp_ram_base_out,
	output reg [31:0] rp_boot_base_out,
	output reg [31:0] rp_other_sp_out,
	output reg core_revcarry_dis,
	output reg core_shadow_ext_dis,
	output reg core_ibuf_dis
);

////////////////////////////////////////////////////////////////////////////////
// Register state
reg [`CFP_CTRL_W-1:0] ctrl;
reg fault_err;
reg fault_lost;
reg [ADDR_W-1:0] fault_addr_q;
reg [DATA_W-1:0] fault_data_q;
reg [1:0] fault_size_q;
reg fault_dir_q;
reg fault_type_q;
reg fault_buf_q;
reg [1:0] fault_loc_q;
reg rp_enable;
reg rp_lock;
reg [BASE_W-1:0] rp_flash_base;
reg [BASE_W-1:0] rp_ram_base;
reg [31:0] rp_boot_base;
reg [31:0] rp_other_sp;
reg [`CFP_PC_W-1:0] rp_ill_pc;
reg rp_ill_valid;
reg [`CFP_PC_W-1:0] rp_mis_pc;
reg rp_mis_valid;

wire [31:0] be_mask;
wire [31:0] wd_m;
wire wr_go;
wire rd_ok;
wire cfg_open;
reg mapped;
reg [31:0] next_readdata;

assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
assign wd_m = avs_writedata & be_mask;
// Write lands on the edge where the master sees waitrequest low
assign wr_go = avs_write && !avs_waitrequest;
assign rd_ok = avs_read || avs_write;
assign cfg_open = !rp_enable && !rp_lock;

////////////////////////////////////////////////////////////////////////////////
// Read mux
always @*
begin
	next_readdata = 32'h00000000;
	mapped = 1'b1;
	case (avs_address)
		`CFP_REG_CTRL: next_readdata[`CFP_CTRL_W-1:0] = ctrl;
		`CFP_REG_FSTAT:
		begin
			next_readdata[`CFP_FSTAT_ERR] = fault_err;
			next_readdata[`CFP_FSTAT_LOST] = fault_lost;
		end
		`CFP_REG_FADDR: next_readdata[ADDR_W-1:0] = fault_addr_q;
		`CFP_REG_FATTR:
		begin
			next_readdata[`CFP_FATTR_TYPE] = fault_type_q;
			next_readdata[`CFP_FATTR_BUF] = fault_buf_q;
			next_readdata[`CFP_FATTR_SIZE+1:`CFP_FATTR_SIZE] = fault_size_q;
			next_readdata[`CFP_FATTR_DIR] = fault_dir_q;
			next_readdata[`CFP_FATTR_LOC+1:`CFP_FATTR_LOC] = fault_loc_q;
		end
		`CFP_REG_FDATA: next_readdata[DATA_W-1:0] = fault_data_q;
		`CFP_REG_RPCTRL:
		begin
			next_readdata[`CFP_RP_EN] = rp_enable;
			next_readdata[`CFP_RP_LOCK] = rp_lock;
		end
		`CFP_REG_RPFLASH: next_readdata[BASE_W-1:0] = rp_flash_base;
		`CFP_REG_RPRAM: next_readdata[BASE_W-1:0] = rp_ram_base;
		`CFP_REG_RPBOOT: next_readdata = rp_boot_base;
		`CFP_REG_RPSP: next_readdata = rp_other_sp;
		`CFP_REG_RPILL:
		begin
			next_readdata[`CFP_PC_W-1:0] = rp_ill_pc;
			next_readdata[`CFP_PC_VALID] = rp_ill_valid;
		end
		`CFP_REG_RPMIS:
		begin
			next_readdata[`CFP_PC_W-1:0] = rp_mis_pc;
			next_readdata[`CFP_PC_VALID] = rp_mis_valid;
		end
		default: mapped = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave: one wait cycle per access
always @(posedge mclk)
begin
	if (!rst_n)
	begin
		avs_waitrequest <= 1'b1;
		avs_readdata <= 32'h00000000;
		avs_response <= `CFP_RESP_OK;
	end
	else if (rd_ok && avs_waitrequest)
	begin
		avs_waitrequest <= 1'b0;
		avs_readdata <= avs_read ? next_readdata : 32'h00000000;
		avs_response <= mapped ? `CFP_RESP_OK : `CFP_RESP_SLVERR;
	end
	else
	begin
		avs_waitrequest <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control and protection registers
always @(posedge mclk)
begin
	if (!rst_n)
	begin
		ctrl <= `CFP_CTRL_RESET;
		rp_enable <= 1'b0;
		rp_lock <= 1'b0;
		rp_flash_base <= {BASE_W{1'b0}};
		rp_ram_base <= {BASE_W{1'b0}};
		rp_boot_base <= 32'h00000000;
		rp_other_sp <= 32'h00000000;
	end
	else if (wr_go)
	begin
		if (avs_address == `CFP_REG_CTRL && avs_byteenable[0])
			ctrl <= avs_writedata[`CFP_CTRL_W-1:0];
		if (avs_address == `CFP_REG_RPCTRL && avs_byteenable[0] && !rp_lock)
		begin
			rp_enable <= avs_writedata[`CFP_RP_EN];
			rp_lock <= avs_writedata[`CFP_RP_LOCK];
		end
		if (cfg_open)
		begin
			if (avs_address == `CFP_REG_RPFLASH)
				rp_flash_base <= (rp_flash_base & ~be_mask[BASE_W-1:0]) | wd_m[BASE_W-1:0];
			if (avs_address == `CFP_REG_RPRAM)
				rp_ram_base <= (rp_ram_base & ~be_mask[BASE_W-1:0]) | wd_m[BASE_W-1:0];
			if (avs_address == `CFP_REG_RPBOOT)
				rp_boot_base <= (rp_boot_base & ~be_mask) | wd_m;
			if (avs_address == `CFP_REG_RPSP)
				rp_other_sp <= (rp_other_sp & ~be_mask) | wd_m;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Core fault capture and flags
wire clr_err;
wire clr_lost;
wire clr_ill;
wire clr_mis;
assign clr_err = wr_go && avs_address == `CFP_REG_FSTAT && wd_m[`CFP_FSTAT_ERR];
assign clr_lost = wr_go && avs_address == `CFP_REG_FSTAT && wd_m[`CFP_FSTAT_LOST];
assign clr_ill = wr_go && avs_address == `CFP_REG_RPILL && wd_m[`CFP_PC_VALID];
assign clr_mis = wr_go && avs_address == `CFP_REG_RPMIS && wd_m[`CFP_PC_VALID];

always @(posedge mclk)
begin
	if (!rst_n)
	begin
		fault_err <= 1'b0;
		fault_lost <= 1'b0;
		fault_addr_q <= {ADDR_W{1'b0}};
		fault_data_q <= {DATA_W{1'b0}};
		fault_size_q <= `CFP_SIZE_8;
		fault_dir_q <= 1'b0;
		fault_type_q <= 1'b0;
		fault_buf_q <= 1'b0;
		fault_loc_q <= `CFP_LOC_INSTR;
		fault_irq <= 1'b0;
	end
	else
	begin
		fault_irq <= fault_valid && ctrl[`CFP_CTRL_IRQ_EN];
		// New fault outranks a clear in the same cycle
		if (fault_valid)
			fault_err <= 1'b1;
		else if (clr_err)
			fault_err <= 1'b0;
		if (fault_valid && fault_err)
			fault_lost <= 1'b1;
		else if (clr_lost)
			fault_lost <= 1'b0;
		if (fault_valid)
		begin
			fault_addr_q <= fault_addr;
			fault_size_q <= fault_size;
			fault_dir_q <= fault_write;
			fault_type_q <= fault_data;
			fault_buf_q <= fault_bufferable;
			fault_loc_q <= fault_bus;
			if (fault_write && fault_data)
				fault_data_q <= fault_wdata;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Protection fault program counters
always @(posedge mclk)
begin
	if (!rst_n)
	begin
		rp_ill_pc <= {`CFP_PC_W{1'b0}};
		rp_ill_valid <= 1'b0;
		rp_mis_pc <= {`CFP_PC_W{1'b0}};
		rp_mis_valid <= 1'b0;
	end
	else
	begin
		if (rp_illegal_fault)
		begin
			rp_ill_pc <= program_counter;
			rp_ill_valid <= 1'b1;
		end
		else if (clr_ill)
			rp_ill_valid <= 1'b0;
		if (rp_misaligned_fault)
		begin
			rp_mis_pc <= program_counter;
			rp_mis_valid <= 1'b1;
		end
		else if (clr_mis)
			rp_mis_valid <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Flash access policy
wire flash_idle;
assign flash_idle = flash_req && !flash_go && !flash_berr;

always @(posedge mclk)
begin
	if (!rst_n)
	begin
		flash_go <= 1'b0;
		flash_berr <= 1'b0;
		flash_stall <= 1'b0;
	end
	else
	begin
		flash_berr <= flash_idle && flash_cmd_busy && ctrl[`CFP_CTRL_STALL_DIS];
		flash_stall <= flash_idle && flash_cmd_busy && !ctrl[`CFP_CTRL_STALL_DIS];
		flash_go <= flash_idle && !flash_cmd_busy;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Core feature controls and protection outputs
always @(posedge mclk)
begin
	if (!rst_n)
	begin
		core_revcarry_dis <= 1'b0;
		core_shadow_ext_dis <= 1'b0;
		core_ibuf_dis <= 1'b0;
		rp_enable_out <= 1'b0;
		rp_flash_base_out <= {BASE_W{1'b0}};
		rp_ram_base_out <= {BASE_W{1'b0}};
		rp_boot_base_out <= 32'h00000000;
		rp_other_sp_out <= 32'h00000000;
	end
	else
	begin
		core_revcarry_dis <= ctrl[`CFP_CTRL_REVC_DIS];
		core_shadow_ext_dis <= ctrl[`CFP_CTRL_SHADOW_DIS];
		core_ibuf_dis <= ctrl[`CFP_CTRL_IBUF_DIS];
		rp_enable_out <= rp_enable;
		// Region settings reach the checker only while enabled
		rp_flash_base_out <= rp_enable ? rp_flash_base : {BASE_W{1'b0}};
		rp_ram_base_out <= rp_enable ? rp_ram_base : {BASE_W{1'b0}};
		rp_boot_base_out <= rp_enable ? rp_boot_base : 32'h00000000;
		rp_other_sp_out <= rp_enable ? rp_other_sp : 32'h00000000;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Crossbar arbitration
cfp_arbiter u_arbiter
(
	.mclk(mclk),
	.rst_n(rst_n),
	.round_robin(ctrl[`CFP_CTRL_ARB_RR]),
	.core_req(xbar_core_req),
	.dma_req(xbar_dma_req),
	.grant_core(xbar_grant_core),
	.grant_dma(xbar_grant_dma)
);

endmodule // cfp_top

// ==== dv/cfp_core_model.sv ====
`timescale 1ns/1ps
// Core side of the flash path: request held until answered
module cfp_core_model
(
	input logic mclk,
	input logic rst_n,
	input logic start,
	input logic flash_go,
	input logic flash_berr,
	output logic flash_req
);
	logic pend;
	// Dropped in the cycle the answer shows
	assign flash_req = pend && !flash_go && !flash_berr;
	always @(posedge mclk)
	begin
		if (!rst_n || flash_go || flash_berr)
			pend <= 1'b0;
		else if (start)
			pend <= 1'b1;
	end
endmodule // cfp_core_model

// ==== dv/cfp_top_sva.sv ====
`timescale 1ns/1ps
module cfp_top_chk
#(
	parameter BASE_W = 8
)
(
	input logic mclk,
	input logic rst_n,
	input logic avs_waitrequest,
	input logic fault_valid,
	input logic fault_irq,
	input logic flash_req,
	input logic flash_cmd_busy,
	input logic flash_go,
	input logic flash_berr,
	input logic flash_stall,
	input logic xbar_core_req,
	input logic xbar_dma_req,
	input logic xbar_grant_core,
	input logic xbar_grant_dma,
	input logic rp_enable_out,
	input logic [BASE_W-1:0] rp_flash_base_out,
	input logic [BASE_W-1:0] rp_ram_base_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_go_idle;
		flash_req && !flash_cmd_busy && !flash_go && !flash_berr && !flash_stall |=> flash_go;
	endproperty
	a_go_idle: assert property (p_go_idle) else $error("idle flash access not granted");
	property p_berr_busy;
		flash_berr |-> $past(flash_cmd_busy);
	endproperty
	a_berr_busy: assert property (p_berr_busy) else $error("bus error without command");
	property p_stall_quiet;
		flash_stall |-> !flash_berr && !flash_go;
	endproperty
	a_stall_quiet: assert property (p_stall_quiet) else $error("answer while stalled");
	property p_irq_cause;
		fault_irq |-> $past(fault_valid);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt without fault");
	property p_core_alone;
		xbar_core_req && !xbar_dma_req |=> xbar_grant_core && !xbar_grant_dma;
	endproperty
	a_core_alone: assert property (p_core_alone) else $error("core not granted");
	property p_contend;
		xbar_core_req && xbar_dma_req |=> xbar_grant_core != xbar_grant_dma;
	endproperty
	a_contend: assert property (p_contend) else $error("contention not one grant");
	property p_base_gate;
		!rp_enable_out ##1 !rp_enable_out |-> rp_flash_base_out == 0 && rp_ram_base_out == 0;
	endproperty
	a_base_gate: assert property (p_base_gate) else $error("region used while off");
	property p_wait_pulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
endmodule // cfp_top_chk
////////////////////////////////////////
bind cfp_top cfp_top_chk #(.BASE_W(BASE_W)) u_chk (.mclk(mclk), .rst_n(rst_n),
	.avs_waitrequest(avs_waitrequest), .fault_valid(fault_valid), .fault_irq(fault_irq),
	.flash_req(flash_req), .flash_cmd_busy(flash_cmd_busy), .flash_go(flash_go),
	.flash_berr(flash_berr), .flash_stall(flash_stall), .xbar_core_req(xbar_core_req),
	.xbar_dma_req(xbar_dma_req), .xbar_grant_core(xbar_grant_core),
	.xbar_grant_dma(xbar_grant_dma), .rp_enable_out(rp_enable_out),
	.rp_flash_base_out(rp_flash_base_out), .rp_ram_base_out(rp_ram_base_out));

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`include "cfp_defs.vh"
module tb_top;
	logic mclk, rst_n, avs_read, avs_write, fault_valid, fault_write, fault_data;
	logic fault_bufferable, flash_cmd_busy, xbar_core_req, xbar_dma_req, start;
	logic rp_illegal_fault, rp_misaligned_fault;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q, fault_addr, fault_wdata, exp;
	logic [1:0] avs_response, r, fault_size, fault_bus;
	logic [20:0] program_counter;
	logic avs_waitrequest, fault_irq, flash_req, flash_go, flash_berr, flash_stall;
	logic xbar_grant_core, xbar_grant_dma, rp_enable_out, revc, shad, ibuf;
	logic [7:0] fbase, rbase;
	logic [31:0] bbase, osp;
	logic [3:0] be;
	logic [8:0] rows [0:5];
	integer mismatches, checks_done, i, n;
	cfp_top DUT (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
		.avs_readdata(avs_readdata), .avs_response(avs_response),
		.avs_waitrequest(avs_waitrequest), .fault_valid(fault_valid), .fault_addr(fault_addr),
		.fault_wdata(fault_wdata), .fault_size(fault_size), .fault_write(fault_write),
		.fault_data(fault_data), .fault_bufferable(fault_bufferable), .fault_bus(fault_bus),
		.fault_irq(fault_irq), .flash_req(flash_req), .flash_cmd_busy(flash_cmd_busy),
		.flash_go(flash_go), .flash_berr(flash_berr), .flash_stall(flash_stall),
		.xbar_core_req(xbar_core_req), .xbar_dma_req(xbar_dma_req),
		.xbar_grant_core(xbar_grant_core), .xbar_grant_dma(xbar_grant_dma),
		.rp_illegal_fault(rp_illegal_fault), .rp_misaligned_fault(rp_misaligned_fault),
		.program_counter(program_counter), .rp_enable_out(rp_enable_out),
		.rp_flash_base_out(fbase), .rp_ram_base_out(rbase), .rp_boot_base_out(bbase),
		.rp_other_sp_out(osp), .core_revcarry_dis(revc), .core_shadow_ext_dis(shad),
		.core_ibuf_dis(ibuf));
	cfp_core_model u_core (.mclk(mclk), .rst_n(rst_n), .start(start), .flash_go(flash_go),
		.flash_berr(flash_berr), .flash_req(flash_req));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e)
			begin
				mismatches = mismatches + 1;
				$display("wrong value %s expected %h seen %h", s, e, g);
			end
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		begin
			@(posedge mclk);
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= w;
			avs_read <= !w;
			n = 0;
			do
			begin
				@(posedge mclk);
				n = n + 1;
			end
			while (avs_waitrequest !== 1'b0);
			q = avs_readdata;
			r = avs_response;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			repeat (2) @(posedge mclk);
		end
	endtask
	task flt(input logic [1:0] k, input logic w);
		begin
			@(posedge mclk);
			fault_addr <= 32'h0000_1230 + k;
			fault_wdata <= 32'hA5A5_0000 + k;
			fault_size <= k;
			fault_bus <= k;
			fault_write <= w;
			fault_data <= (k != 2'h0);
			fault_bufferable <= k[1];
			fault_valid <= 1'b1;
			@(posedge mclk);
			fault_valid <= 1'b0;
			@(posedge mclk);
			q = 32'(fault_irq);
		end
	endtask
	task fw(input logic s);
		begin
			start <= s;
			n = 0;
			do
			begin
				@(posedge mclk);
				start <= 1'b0;
				n = n + 1;
			end
			while (flash_go !== 1'b1 && flash_berr !== 1'b1 && n < 20);
			q = 32'({flash_go, flash_berr});
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", checks_done, mismatches);
			if (mismatches == 0 && checks_done > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial
	begin
		#100000;
		mismatches = mismatches + 1;
		tally_and_finish;
	end
	////////////////////////////////////////
	initial
	begin
		{rst_n, avs_read, avs_write, fault_valid, fault_write, fault_data, start} = 7'h00;
		{fault_bufferable, flash_cmd_busy, xbar_core_req, xbar_dma_req} = 4'h0;
		{rp_illegal_fault, rp_misaligned_fault, avs_address, fault_size, fault_bus} = 10'h000;
		{avs_writedata, fault_addr, fault_wdata, program_counter} = 117'h0;
		{mismatches, checks_done} = 64'h0;
		be = 4'hF;
		rows = '{9'h021, 9'h042, 9'h084, 9'h0E7, 9'h118, 9'h000};
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		bus(0, `CFP_REG_CTRL, 0);
		chk("ctrl reset", 0, q);
		chk("resp ok", 32'(`CFP_RESP_OK), 32'(r));
		for (i = 0; i < 6; i = i + 1)
		begin
			bus(1, `CFP_REG_CTRL, 32'(rows[i][8:3]));
			bus(0, `CFP_REG_CTRL, 0);
			chk("ctrl", 32'(rows[i][8:3]), q);
			chk("core disables", 32'(rows[i][2:0]), 32'({ibuf, shad, revc}));
		end
		bus(1, `CFP_REG_CTRL, 32'h20);
		for (i = 0; i < 3; i = i + 1)
		begin
			flt(i[1:0], i == 1);
			chk("irq", 1, q);
			bus(0, `CFP_REG_FADDR, 0);
			chk("fault addr", 32'h1230 + i, q);
			exp = 32'((i != 0) | (i[1] << 2) | (i << 4) | ((i == 1) << 6) | (i << 8));
			bus(0, `CFP_REG_FATTR, 0);
			chk("fault attr", exp, q);
		end
		bus(0, `CFP_REG_FDATA, 0);
		chk("fault data", 32'hA5A5_0001, q);
		bus(0, `CFP_REG_FSTAT, 0);
		chk("status lost", 3, q);
		bus(1, `CFP_REG_FSTAT, 2);
		bus(0, `CFP_REG_FSTAT, 0);
		chk("status clear lost", 1, q);
		bus(1, `CFP_REG_FSTAT, 1);
		bus(1, `CFP_REG_CTRL, 0);
		flt(0, 0);
		chk("irq masked", 0, q);
		bus(0, `CFP_REG_FSTAT, 0);
		chk("status err only", 1, q);
		bus(1, `CFP_REG_CTRL, 2);
		flash_cmd_busy <= 1'b1;
		fw(1);
		chk("flash no stall", 1, q);
		bus(1, `CFP_REG_CTRL, 0);
		fw(1);
		chk("flash held", 0, q);
		chk("flash stall", 1, 32'(flash_stall));
		flash_cmd_busy <= 1'b0;
		fw(0);
		chk("flash after cmd", 2, q);
		fw(1);
		chk("flash idle", 2, q);
		bus(1, `CFP_REG_RPFLASH, 32'h3C);
		bus(1, `CFP_REG_RPRAM, 32'h5A);
		chk("bases off", 0, 32'({rbase, fbase}));
		bus(1, `CFP_REG_RPCTRL, 1);
		bus(1, `CFP_REG_RPFLASH, 32'h11);
		chk("prot on", 1, 32'(rp_enable_out));
		chk("bases on", 32'h5A3C, 32'({rbase, fbase}));
		bus(1, `CFP_REG_RPCTRL, 3);
		bus(1, `CFP_REG_RPCTRL, 0);
		chk("prot locked", 1, 32'(rp_enable_out));
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		bus(1, `CFP_REG_RPFLASH, 32'h11);
		bus(1, `CFP_REG_RPBOOT, 32'h0001_2300);
		be <= 4'h3;
		bus(1, `CFP_REG_RPSP, 32'hFFFF_4560);
		be <= 4'hF;
		chk("boot off", 0, bbase);
		bus(1, `CFP_REG_RPCTRL, 1);
		chk("unlocked by reset", 32'h11, 32'(fbase));
		chk("boot on", 32'h0001_2300, bbase);
		chk("sp lanes", 32'h0000_4560, osp);
		for (i = 0; i < 2; i = i + 1)
		begin
			@(posedge mclk);
			program_counter <= 21'h1ABCD0 + i;
			{rp_misaligned_fault, rp_illegal_fault} <= 2'b01 << i;
			@(posedge mclk);
			{rp_misaligned_fault, rp_illegal_fault} <= 2'b00;
			bus(0, `CFP_REG_RPILL + i, 0);
			chk("fault pc", {1'b1, 10'h0, 21'h1ABCD0 + 21'(i)}, q);
			bus(1, `CFP_REG_RPILL + i, 32'h8000_0000);
			bus(0, `CFP_REG_RPILL + i, 0);
			chk("pc valid", 0, 32'(q[31]));
		end
		bus(0, 4'hD, 0);
		chk("unmapped resp", 32'(`CFP_RESP_SLVERR), 32'(r));
		{xbar_core_req, xbar_dma_req} <= 2'b11;
		bus(1, `CFP_REG_CTRL, 0);
		chk("fixed grant", 2, 32'({xbar_grant_core, xbar_grant_dma}));
		bus(1, `CFP_REG_CTRL, 1);
		q = 32'(xbar_grant_core);
		@(posedge mclk);
		chk("rr alternate", 32'(!q[0]), 32'(xbar_grant_core));
		{xbar_core_req, xbar_dma_req} <= 2'b10;
		repeat (2) @(posedge mclk);
		chk("core alone", 2, 32'({xbar_grant_core, xbar_grant_dma}));
		{xbar_core_req, xbar_dma_req} <= 2'b00;
		tally_and_finish;
	end
endmodule // tb_top
